// file: hw/lds_sequencer.sv
// start-up sequencer and switching clock supervision for a four-channel led driver
// assumes analog comparators and the host pins arrive asynchronously to ref_clk
//
// Operation
// - stay unpowered until supply lockout clears and enable is high.
// - power-up turns on disconnect drive, then checks every sink channel.
// - detect phase starts once the gate comparator reports gate level reached.
// - after pin above 120 mV, wait 3000-4000 switching cycles, then decide.
// - classify: below 70 mV shorted, near 150 mV unused, near 325 mV used.
// - any shorted channel halts power-up; no soft start until released.
// - a released short is checked again before power-up continues.
// - an unused channel is kept out of regulation from then on.
// - soft start uses soft-start sink current and reduced switch limit.
// - enough sink voltage raises to full current and full switch limit.
// - switching frequency never exceeds 3.5 MHz.
// - sync pin shorted low during operation shuts the device down.
// - no start while sync pin low; start on pin high or sync clock.
// - a detected external clock takes over without touching sink current.
// - lost sync reverts to resistor-set rate, pausing at most about 7 us.
// - sync low over 7 us shuts down: no switching, switch open, sinks off.
// - enable low for 32,750 switching cycles enters low-power mode.
// - sync pin released after the stuck-low shutdown restarts via soft start.
// - lockout clears above 4.35 V; first enable pulse meets minimum on-time.
// - enable low turns off boost and sinks, internal state kept alive.
`default_nettype none
module lds_sequencer #(
    parameter int unsigned DETECT_TICKS = lds_pkg::DETECT_MIN_TICKS,
    parameter int unsigned LOW_POWER_TICKS = lds_pkg::EN_LOW_TICKS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic supply_undervoltage_lockout_clear,
    input wire logic enable_pin,
    input wire logic gate_at_level,
    input wire logic [3:0] led_above_arm,
    input wire logic [3:0] led_below_short,
    input wire logic [3:0] led_above_inuse,
    input wire logic sink_sense_ok,
    input wire logic freq_set_sync_pin,
    input wire logic [11:0] rset_period,
    output logic disconnect_on,
    output logic [3:0] sink_enable,
    output logic softstart_sink_current,
    output logic softstart_switch_limit,
    output logic boost_pulse,
    output logic sync_mode,
    output logic [3:0] channel_used,
    output logic [3:0] channel_short,
    output logic stuck_shutdown,
    output logic low_power
);
    localparam int unsigned SYN_W = 17;

    // synchroniser stages
    logic [SYN_W-1:0] meta;
    logic [SYN_W-1:0] syn;
    logic s_supply_undervoltage_lockout;
    logic s_en;
    logic s_gate;
    logic [3:0] s_arm;
    logic [3:0] s_short;
    logic [3:0] s_inuse;
    logic s_sense;
    logic s_sync;

    // sync watch results
    logic sync_rise;
    logic sync_present;
    logic stuck_low;

    // switching clock state
    logic [11:0] sw_cnt;
    logic [11:0] next_sw_cnt;
    logic next_sync_mode;
    logic [11:0] eff_period;
    logic tick;

    // sequencer state
    lds_pkg::lds_state_e state;
    lds_pkg::lds_state_e next_state;
    logic [11:0] det_cnt;
    logic [11:0] next_det_cnt;
    logic [7:0] en_on_cnt;
    logic [7:0] next_en_on_cnt;
    logic [14:0] en_low_cnt;
    logic [14:0] next_en_low_cnt;
    logic [3:0] next_channel_used;
    logic [3:0] next_channel_short;
    logic pin_ok;

    // output next values
    logic next_disconnect_on;
    logic [3:0] next_sink_enable;
    logic next_ss_current;
    logic next_ss_limit;
    logic next_boost_pulse;
    logic next_stuck_shutdown;
    logic next_low_power;
    logic boost_run;

    // two flops on every asynchronous input before any logic reads it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta <= 17'h00001; // sync pin stage resets to its idle high level
            syn <= 17'h00001;
        end else begin
            meta <= {supply_undervoltage_lockout_clear, enable_pin, gate_at_level, led_above_arm,
                     led_below_short, led_above_inuse, sink_sense_ok, freq_set_sync_pin};
            syn <= meta;
        end
    end

    assign {s_supply_undervoltage_lockout, s_en, s_gate, s_arm, s_short, s_inuse, s_sense, s_sync} = syn;

    // sync edge, clock presence and stuck-low detection
    lds_sync_watch #(
        .LOSS_CYC(lds_pkg::SYNC_LOSS_CYC)
    ) u_watch (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sync_level(s_sync),
        .sync_rise(sync_rise),
        .sync_present(sync_present),
        .stuck_low(stuck_low)
    );

    // resistor-set period, never shorter than the frequency clamp
    assign eff_period = (rset_period < lds_pkg::MIN_SW_CYC) ?
                        lds_pkg::MIN_SW_CYC : rset_period;

    // switching tick from the internal divider or the external clock
    always_comb begin
        if (sync_mode) begin
            // sync edges closer than the clamp are skipped
            tick = sync_rise && (sw_cnt >= lds_pkg::MIN_SW_CYC - 12'h001);
        end else begin
            tick = (sw_cnt >= eff_period - 12'h001);
        end
        // a lost clock gives no ticks until the watch times out
        next_sync_mode = sync_present;
        if (tick || (next_sync_mode != sync_mode)) begin
            next_sw_cnt = lds_pkg::CNT_RST;
        end else begin
            next_sw_cnt = lds_pkg::lds_sat_inc(sw_cnt);
        end
    end

    // switching clock registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sw_cnt <= lds_pkg::CNT_RST;
            sync_mode <= 1'b0;
        end else begin
            sw_cnt <= next_sw_cnt;
            sync_mode <= next_sync_mode;
        end
    end

    // pin released high or carrying a clock
    assign pin_ok = s_sync | sync_present;

    // power-up sequence
    always_comb begin
        next_state = state;
        next_det_cnt = det_cnt;
        next_en_on_cnt = en_on_cnt;
        next_en_low_cnt = en_low_cnt;
        next_channel_used = channel_used;
        next_channel_short = channel_short;
        // enable low time counted in switching cycles
        if (s_en || state == lds_pkg::LDS_OFF || state == lds_pkg::LDS_LOW_POWER) begin
            next_en_low_cnt = '0;
        end else if (tick && en_low_cnt != 15'h7fff) begin
            next_en_low_cnt = en_low_cnt + 15'h0001;
        end
        case (state)
            lds_pkg::LDS_OFF: begin
                // first enable pulse must meet the minimum on-time
                if (!s_en) begin
                    next_en_on_cnt = 8'h00;
                end else if (en_on_cnt != 8'hff) begin
                    next_en_on_cnt = en_on_cnt + 8'h01;
                end
                if (s_supply_undervoltage_lockout && s_en && pin_ok &&
                    en_on_cnt >= lds_pkg::ENABLE_MIN_ON_CYC) begin
                    next_state = lds_pkg::LDS_WAIT_GATE;
                end
            end
            lds_pkg::LDS_WAIT_GATE: begin
                if (s_gate) begin
                    next_state = lds_pkg::LDS_ARM;
                end
            end
            lds_pkg::LDS_ARM: begin
                next_det_cnt = lds_pkg::CNT_RST;
                if (|s_arm) begin
                    next_state = lds_pkg::LDS_DETECT;
                end
            end
            lds_pkg::LDS_DETECT: begin
                if (tick) begin
                    next_det_cnt = lds_pkg::lds_sat_inc(det_cnt);
                end
                if (det_cnt >= 12'(DETECT_TICKS)) begin
                    next_channel_short = s_short;
                    next_channel_used = s_inuse & ~s_short;
                    if (|s_short) begin
                        next_state = lds_pkg::LDS_SHORT_HALT;
                    end else begin
                        next_state = lds_pkg::LDS_SOFT_START;
                    end
                end
            end
            lds_pkg::LDS_SHORT_HALT: begin
                next_channel_short = s_short;
                if (~|s_short) begin
                    next_state = lds_pkg::LDS_ARM;
                end
            end
            lds_pkg::LDS_SOFT_START: begin
                if (s_sense) begin
                    next_state = lds_pkg::LDS_RUN;
                end
            end
            lds_pkg::LDS_RUN: begin
                next_state = lds_pkg::LDS_RUN;
            end
            lds_pkg::LDS_STUCK_SHUT: begin
                // a short still latched keeps power-up halted after the restart
                if (!stuck_low && |channel_short) begin
                    next_state = lds_pkg::LDS_SHORT_HALT;
                end else if (!stuck_low) begin
                    next_state = lds_pkg::LDS_SOFT_START;
                end
            end
            lds_pkg::LDS_LOW_POWER: begin
                if (s_en) begin
                    next_state = lds_pkg::LDS_OFF;
                end
            end
            default: begin
                next_state = lds_pkg::LDS_OFF;
            end
        endcase
        // overrides by priority: lockout, low power, stuck-low pin
        if (state != lds_pkg::LDS_OFF && state != lds_pkg::LDS_LOW_POWER) begin
            if (stuck_low && state != lds_pkg::LDS_STUCK_SHUT) begin
                next_state = lds_pkg::LDS_STUCK_SHUT;
            end
            if (en_low_cnt >= 15'(LOW_POWER_TICKS)) begin
                next_state = lds_pkg::LDS_LOW_POWER;
            end
        end
        if (!s_supply_undervoltage_lockout) begin
            next_state = lds_pkg::LDS_OFF;
        end
        if (next_state == lds_pkg::LDS_OFF && state != lds_pkg::LDS_OFF) begin
            next_en_on_cnt = 8'h00;
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= lds_pkg::LDS_OFF;
            det_cnt <= lds_pkg::CNT_RST;
            en_on_cnt <= 8'h00;
            en_low_cnt <= 15'h0000;
            channel_used <= lds_pkg::CHAN_RST;
            channel_short <= lds_pkg::CHAN_RST;
        end else begin
            state <= next_state;
            det_cnt <= next_det_cnt;
            en_on_cnt <= next_en_on_cnt;
            en_low_cnt <= next_en_low_cnt;
            channel_used <= next_channel_used;
            channel_short <= next_channel_short;
        end
    end

    // pin drive decoded from state; enable low stops boost and sinks
    always_comb begin
        boost_run = s_en && (state == lds_pkg::LDS_SOFT_START ||
                             state == lds_pkg::LDS_RUN);
        next_disconnect_on = !(state == lds_pkg::LDS_OFF ||
                               state == lds_pkg::LDS_STUCK_SHUT ||
                               state == lds_pkg::LDS_LOW_POWER);
        next_sink_enable = boost_run ? channel_used : 4'h0;
        next_ss_current = (state != lds_pkg::LDS_RUN);
        next_ss_limit = (state != lds_pkg::LDS_RUN);
        next_boost_pulse = tick && boost_run;
        next_stuck_shutdown = (state == lds_pkg::LDS_STUCK_SHUT);
        next_low_power = (state == lds_pkg::LDS_LOW_POWER);
    end

    // output registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            disconnect_on <= 1'b0;
            sink_enable <= 4'h0;
            softstart_sink_current <= 1'b1;
            softstart_switch_limit <= 1'b1;
            boost_pulse <= 1'b0;
            stuck_shutdown <= 1'b0;
            low_power <= 1'b0;
        end else begin
            disconnect_on <= next_disconnect_on;
            sink_enable <= next_sink_enable;
            softstart_sink_current <= next_ss_current;
            softstart_switch_limit <= next_ss_limit;
            boost_pulse <= next_boost_pulse;
            stuck_shutdown <= next_stuck_shutdown;
            low_power <= next_low_power;
        end
    end
endmodule : lds_sequencer
`default_nettype wire

// file: common/lds_pkg.sv
// constants and types for the led driver start-up and sync sequencer
// assumes a 250 MHz reference clock; switching ticks are derived from it
`default_nettype none
package lds_pkg;
    // reference clock
    localparam int unsigned REF_CLK_MHZ = 250;
    localparam int unsigned REF_PERIOD_NS = 4;
    localparam int unsigned NUM_CHAN = 4;
    localparam int unsigned CNT_W = 12;
    // sync loss and stuck-low window, longest time so rounded down
    localparam int unsigned SYNC_LOSS_NS = 7000;
    localparam logic [11:0] SYNC_LOSS_CYC = 12'(SYNC_LOSS_NS / REF_PERIOD_NS);
    // enable_min_on_time, least time so rounded up
    localparam int unsigned ENABLE_MIN_ON_NS = 750;
    localparam logic [7:0] ENABLE_MIN_ON_CYC =
        8'((ENABLE_MIN_ON_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    // switching frequency clamp, shortest period rounded up
    localparam int unsigned MAX_SW_KHZ = 3500;
    localparam logic [11:0] MIN_SW_CYC =
        12'((REF_CLK_MHZ * 1000 + MAX_SW_KHZ - 1) / MAX_SW_KHZ);
    // led detect window in switching cycles
    localparam int unsigned DETECT_MIN_TICKS = 3000;
    localparam int unsigned DETECT_MAX_TICKS = 4000;
    // enable low time before low-power shutdown, in switching cycles
    localparam int unsigned EN_LOW_TICKS = 32750;
    // default resistor-set period in reference cycles (1 MHz)
    localparam logic [11:0] RSET_PERIOD_DEF = 12'h0fa;
    // reset values
    localparam logic [11:0] CNT_RST = 12'h000;
    localparam logic [3:0] CHAN_RST = 4'h0;

    // sequencer states
    typedef enum logic [3:0] {
        LDS_OFF,
        LDS_WAIT_GATE,
        LDS_ARM,
        LDS_DETECT,
        LDS_SHORT_HALT,
        LDS_SOFT_START,
        LDS_RUN,
        LDS_STUCK_SHUT,
        LDS_LOW_POWER
    } lds_state_e;

    // saturating increment for counters
    function automatic logic [11:0] lds_sat_inc(input logic [11:0] v);
        return (v == 12'hfff) ? v : v + 12'h001;
    endfunction : lds_sat_inc
endpackage : lds_pkg
`default_nettype wire

// file: hw/lds_sync_watch.sv
// watches the synchronised freq_set_sync_pin level on the reference clock
// assumes its input has already passed a two-flop synchroniser
`default_nettype none
module lds_sync_watch #(
    parameter logic [11:0] LOSS_CYC = lds_pkg::SYNC_LOSS_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sync_level,
    output logic sync_rise,
    output logic sync_present,
    output logic stuck_low
);
    logic prev_level;
    logic seen_edge;
    logic [11:0] gap_cnt;
    logic [11:0] low_cnt;
    logic next_prev_level;
    logic next_seen_edge;
    logic next_present;
    logic [11:0] next_gap_cnt;
    logic [11:0] next_low_cnt;

    // edge found on the already synchronised level
    assign sync_rise = sync_level & ~prev_level;
    // held low longer than the window means stuck low
    assign stuck_low = (low_cnt > LOSS_CYC);

    // windows timed on the internal clock so they run without sync edges
    always_comb begin
        next_prev_level = sync_level;
        next_gap_cnt = sync_rise ? lds_pkg::CNT_RST : lds_pkg::lds_sat_inc(gap_cnt);
        next_low_cnt = sync_level ? lds_pkg::CNT_RST : lds_pkg::lds_sat_inc(low_cnt);
        next_seen_edge = seen_edge;
        next_present = sync_present;
        if (sync_rise) begin
            next_seen_edge = 1'b1;
            // two edges inside the window make a clock
            if (seen_edge && gap_cnt < LOSS_CYC) begin
                next_present = 1'b1;
            end
        end else if (gap_cnt >= LOSS_CYC) begin
            next_present = 1'b0;
            next_seen_edge = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prev_level <= 1'b1; // pin idles high, so no false edge after reset
            seen_edge <= 1'b0;
            sync_present <= 1'b0;
            gap_cnt <= lds_pkg::CNT_RST;
            low_cnt <= lds_pkg::CNT_RST;
        end else begin
            prev_level <= next_prev_level;
            seen_edge <= next_seen_edge;
            sync_present <= next_present;
            gap_cnt <= next_gap_cnt;
            low_cnt <= next_low_cnt;
        end
    end
endmodule : lds_sync_watch
`default_nettype wire

// file: verification/lds_sequencer_checker.sv
// checker for the start-up sequencer: power gating, shutdown and clamp relations
// assumes it is bound to lds_sequencer and sees only that module's ports
`default_nettype none
module lds_sequencer_checker #(
    parameter int unsigned DETECT_TICKS = lds_pkg::DETECT_MIN_TICKS,
    parameter int unsigned LOW_POWER_TICKS = lds_pkg::EN_LOW_TICKS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic supply_undervoltage_lockout_clear,
    input wire logic enable_pin,
    input wire logic gate_at_level,
    input wire logic [3:0] led_above_arm,
    input wire logic [3:0] led_below_short,
    input wire logic [3:0] led_above_inuse,
    input wire logic sink_sense_ok,
    input wire logic freq_set_sync_pin,
    input wire logic [11:0] rset_period,
    input wire logic disconnect_on,
    input wire logic [3:0] sink_enable,
    input wire logic softstart_sink_current,
    input wire logic softstart_switch_limit,
    input wire logic boost_pulse,
    input wire logic sync_mode,
    input wire logic [3:0] channel_used,
    input wire logic [3:0] channel_short,
    input wire logic stuck_shutdown,
    input wire logic low_power
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] gap;
    logic [11:0] next_gap;
    logic [11:0] low_cnt;
    logic [11:0] next_low_cnt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // cycles since the last boost pulse and since the sync pin went low, saturating
    always_comb begin
        next_gap = boost_pulse ? 12'h000 : ((gap == 12'hfff) ? gap : gap + 12'h001);
        next_low_cnt = freq_set_sync_pin ? 12'h000 :
            ((low_cnt == 12'hfff) ? low_cnt : low_cnt + 12'h001);
    end

    // registers for the helper counters
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gap <= 12'hfff;
            low_cnt <= 12'h000;
        end else begin
            gap <= next_gap;
            low_cnt <= next_low_cnt;
        end
    end

    // inputs held long enough to pass the synchronisers and the state register
    sequence supply_undervoltage_lockout_low_held;
        !supply_undervoltage_lockout_clear [*8];
    endsequence
    sequence en_low_held;
        !enable_pin [*6];
    endsequence

    supply_undervoltage_lockout_off_a: assert property (supply_undervoltage_lockout_low_held |-> !disconnect_on)
        else $error("disconnect on with lockout set");
    en_low_a: assert property (en_low_held |-> sink_enable == 4'h0 && !boost_pulse)
        else $error("sinks or boost on with enable low");
    unused_out_a: assert property ((sink_enable & ~channel_used) == 4'h0)
        else $error("unused channel sinking");
    short_halt_a: assert property ((|channel_short) && $past(|channel_short)
        |-> !boost_pulse && sink_enable == 4'h0) else $error("power-up went on past a short");
    clamp_gap_a: assert property (boost_pulse |-> gap >= 12'h047)
        else $error("switching period below clamp");
    stuck_off_a: assert property (stuck_shutdown && $past(stuck_shutdown)
        |-> !disconnect_on && !boost_pulse && sink_enable == 4'h0) else $error("shutdown leaks");
    stuck_late_a: assert property (low_cnt == 12'h6e0 |-> stuck_shutdown || !disconnect_on)
        else $error("no shutdown on stuck-low pin");
    stuck_early_a: assert property ($rose(stuck_shutdown) |-> low_cnt > 12'h6d6)
        else $error("stuck-low shutdown too early");
    ss_pair_a: assert property ($fell(softstart_switch_limit) |-> !softstart_sink_current
        && $past(sink_sense_ok, 4)) else $error("current and limit left soft start apart");
    restart_ss_a: assert property ($fell(stuck_shutdown) && !low_power
        |-> softstart_switch_limit) else $error("restart skipped soft start");
    lowpow_off_a: assert property (low_power |-> !disconnect_on && sink_enable == 4'h0)
        else $error("low power with outputs on");
endmodule : lds_sequencer_checker

bind lds_sequencer lds_sequencer_checker #(
    .DETECT_TICKS(DETECT_TICKS), .LOW_POWER_TICKS(LOW_POWER_TICKS)
) lds_sequencer_checker_i (
    .ref_clk(ref_clk), .rstn(rstn), .supply_undervoltage_lockout_clear(supply_undervoltage_lockout_clear), .enable_pin(enable_pin),
    .gate_at_level(gate_at_level), .led_above_arm(led_above_arm),
    .led_below_short(led_below_short), .led_above_inuse(led_above_inuse),
    .sink_sense_ok(sink_sense_ok), .freq_set_sync_pin(freq_set_sync_pin),
    .rset_period(rset_period), .disconnect_on(disconnect_on), .sink_enable(sink_enable),
    .softstart_sink_current(softstart_sink_current),
    .softstart_switch_limit(softstart_switch_limit), .boost_pulse(boost_pulse),
    .sync_mode(sync_mode), .channel_used(channel_used), .channel_short(channel_short),
    .stuck_shutdown(stuck_shutdown), .low_power(low_power)
);
`default_nettype wire

// file: verification/lds_host_model.sv
// host model: drives the dimming enable and the sync pin (released, clocked or held low)
// assumes a pull-up holds the released sync pin high; times in ns
`default_nettype none
module lds_host_model (
    input wire logic en_cmd,
    input wire logic [1:0] sync_cmd,
    output logic enable_pin,
    output var logic freq_set_sync_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] mode = 2'h0;
    realtime rise_at = 0.0;

    // enable follows the command; its rise time gates source changes
    assign enable_pin = en_cmd;
    always @(posedge en_cmd) rise_at = $realtime;

    // sync pin generator, phase unrelated to ref_clk
    initial begin
        freq_set_sync_pin = 1'b0;
        #37;
        forever begin
            if (sync_cmd != mode && (!en_cmd || $realtime - rise_at >= 500.0)) begin
                mode = sync_cmd;
            end
            if (mode == 2'h1) begin
                freq_set_sync_pin = 1'b1; // 160 ns high, 160 ns low
                #160;
                freq_set_sync_pin = 1'b0;
                #160;
            end else begin
                freq_set_sync_pin = (mode == 2'h0); // released pin pulls high
                #20;
            end
        end
    end
endmodule : lds_host_model
`default_nettype wire

// file: verification/test_lds_sequencer.sv
// testbench for the start-up sequencer: power-up, detect, soft start, sync, shutdowns
// assumes lds_host_model for enable and sync; detect and low-power counts shortened
`default_nettype none
module test_lds_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 72;
    localparam int DET = 4;
    localparam int LOWP = 8;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic supply_undervoltage_lockout_clear = 1'b0;
    logic en_cmd = 1'b0;
    logic [1:0] sync_cmd = 2'h2;
    logic gate_at_level = 1'b0;
    logic sink_sense_ok = 1'b0;
    logic [3:0] led_above_arm = 4'h0;
    logic [3:0] led_below_short = 4'h0;
    logic [3:0] led_above_inuse = 4'h0;
    logic enable_pin, sync_pin, disconnect_on, ss_cur, ss_lim, boost_pulse, sync_mode;
    logic stuck_shutdown, low_power;
    logic [3:0] sink_enable, channel_used, channel_short;
    int fail_count = 0;
    int comparisons = 0;

    // rset_period below the clamp, so the clamp sets the tick
    lds_sequencer #(.DETECT_TICKS(DET), .LOW_POWER_TICKS(LOWP)) lds_sequencer_i (
        .ref_clk(ref_clk), .rstn(rstn), .supply_undervoltage_lockout_clear(supply_undervoltage_lockout_clear), .enable_pin(enable_pin),
        .gate_at_level(gate_at_level), .led_above_arm(led_above_arm),
        .led_below_short(led_below_short), .led_above_inuse(led_above_inuse),
        .sink_sense_ok(sink_sense_ok), .freq_set_sync_pin(sync_pin), .rset_period(12'h028),
        .disconnect_on(disconnect_on), .sink_enable(sink_enable),
        .softstart_sink_current(ss_cur), .softstart_switch_limit(ss_lim),
        .boost_pulse(boost_pulse), .sync_mode(sync_mode), .channel_used(channel_used),
        .channel_short(channel_short), .stuck_shutdown(stuck_shutdown), .low_power(low_power)
    );
    lds_host_model lds_host_model_i (
        .en_cmd(en_cmd), .sync_cmd(sync_cmd), .enable_pin(enable_pin),
        .freq_set_sync_pin(sync_pin)
    );

    // 250 MHz clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic cnd(input int k);
        case (k)
            0: return disconnect_on;
            1: return |channel_short;
            2: return sink_enable == 4'hd;
            3: return boost_pulse;
            4: return sync_mode;
            5: return !sync_mode;
            6: return stuck_shutdown;
            default: return low_power;
        endcase
    endfunction : cnd

    // bounded wait on a condition; n is the cycles taken
    task automatic wait_on(input int k, input int bound, output int n);
        n = 0;
        while (cnd(k) !== 1'b1) begin
            if (n == bound) begin
                fail_count++;
                report_and_stop();
            end
            step(1);
            n++;
        end
    endtask : wait_on

    // cycles between two boost pulses
    task automatic gap(output int g);
        int n;
        wait_on(3, 2000, n);
        step(1);
        wait_on(3, 2000, g);
        g = g + 1;
    endtask : gap

    task automatic t_no_start;
        supply_undervoltage_lockout_clear = 1'b1;
        en_cmd = 1'b1;
        step(400);
        chk(4'(disconnect_on), 4'h0);
        en_cmd = 1'b0;
        sync_cmd = 2'h0;
        step(20);
        en_cmd = 1'b1;
        step(100);
        en_cmd = 1'b0;
        step(200);
        chk(4'(disconnect_on), 4'h0);
        supply_undervoltage_lockout_clear = 1'b0;
        en_cmd = 1'b1;
        step(400);
        chk(4'(disconnect_on), 4'h0);
    endtask : t_no_start

    task automatic t_power_up;
        int n;
        led_above_arm = 4'hb;
        led_below_short = 4'h4;
        led_above_inuse = 4'h9;
        supply_undervoltage_lockout_clear = 1'b1;
        wait_on(0, 400, n);
        step(300);
        chk(channel_short | channel_used, 4'h0);
        gate_at_level = 1'b1;
        wait_on(1, 800, n);
        chk(4'(n >= (DET - 1) * TICK && n <= DET * TICK + 120), 4'h1);
        chk(channel_short, 4'h4);
        step(300);
        chk(sink_enable, 4'h0);
        led_below_short = 4'h0;
        led_above_arm = 4'hf;
        led_above_inuse = 4'hd;
        wait_on(2, 1000, n);
        chk(channel_used, 4'hd);
        chk(4'({ss_cur, ss_lim}), 4'h3);
    endtask : t_power_up

    task automatic t_run;
        int g;
        gap(g);
        chk(4'(g == TICK), 4'h1);
        sink_sense_ok = 1'b1;
        step(10);
        chk(4'({ss_cur, ss_lim}), 4'h0);
        chk(sink_enable, 4'hd);
    endtask : t_run

    task automatic t_sync;
        int n;
        int g;
        sync_cmd = 2'h1;
        wait_on(4, 600, n);
        gap(g);
        chk(4'(g == 80), 4'h1);
        chk(sink_enable, 4'hd);
        sync_cmd = 2'h0;
        gap(g);
        chk(4'(g <= 1900), 4'h1);
        wait_on(5, 2000, n);
        gap(g);
        chk(4'(g == TICK), 4'h1);
    endtask : t_sync

    task automatic t_stuck;
        int n;
        sync_cmd = 2'h2;
        step(1700);
        chk(4'(stuck_shutdown), 4'h0);
        wait_on(6, 200, n);
        chk(4'(disconnect_on) | sink_enable, 4'h0);
        sink_sense_ok = 1'b0;
        sync_cmd = 2'h0;
        wait_on(2, 600, n);
        chk(4'({ss_cur, ss_lim, stuck_shutdown}), 4'h6);
    endtask : t_stuck

    task automatic t_enable_low;
        int n;
        en_cmd = 1'b0;
        step(8);
        chk(sink_enable, 4'h0);
        step(LOWP * TICK - 170);
        chk(4'(low_power), 4'h0);
        wait_on(7, 400, n);
        chk(4'(disconnect_on), 4'h0);
        en_cmd = 1'b1;
        wait_on(0, 400, n);
        chk(4'(low_power), 4'h0);
    endtask : t_enable_low

    // reset, then the scenarios in order
    initial begin
        step(20);
        rstn = 1'b1;
        t_no_start();
        t_power_up();
        t_run();
        t_sync();
        t_stuck();
        t_enable_low();
        report_and_stop();
    end
endmodule : test_lds_sequencer
`default_nettype wire
